// File: hdl/flash_cmd_pkg.sv
package flash_cmd_pkg;
  // ****************************************
  // opcodes
  // ****************************************
  localparam logic [7:0] OP_DUAL_OUT   = 8'h3b;
  localparam logic [7:0] OP_DUAL_IO    = 8'hbb;
  localparam logic [7:0] OP_PROGRAM    = 8'h02;
  localparam logic [7:0] OP_SECT_ERA_A = 8'h20;
  localparam logic [7:0] OP_SECT_ERA_B = 8'hd7;
  localparam logic [7:0] OP_BLOCK_ERA  = 8'hd8;
  localparam logic [7:0] OP_CHIP_ERA_A = 8'h60;
  localparam logic [7:0] OP_CHIP_ERA_B = 8'hc7;
  localparam logic [7:0] OP_STAT_READ  = 8'h05;
  localparam logic [7:0] OP_STAT_WRITE = 8'h01;
  localparam logic [7:0] OP_WRITE_ENABLE_CMD       = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE_CMD       = 8'h04;
  // ****************************************
  // bit counts per phase (last index) and top read address
  // ****************************************
  localparam logic [4:0] LAST_OPC_BIT   = 5'h07;
  localparam logic [4:0] LAST_ADDR_BIT  = 5'h17;
  localparam logic [4:0] LAST_ADDR_PAIR = 5'h0b;
  localparam logic [4:0] LAST_DUMMY_1   = 5'h07;
  localparam logic [4:0] LAST_DUMMY_2   = 5'h03;
  localparam logic [18:0] TOP_ADDR      = 19'h7ffff;
  // ****************************************
  // self-timed operation lengths
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS      = 10;
  localparam int unsigned PROGRAM_TIME_US    = 1000;
  localparam int unsigned SECTOR_ERASE_TIME_US = 1000;
  localparam int unsigned BLOCK_ERASE_TIME_US  = 1000;
  localparam int unsigned CHIP_ERASE_TIME_US   = 1000;
  localparam int unsigned PROGRAM_CYCLES =
    PROGRAM_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned SECTOR_ERASE_CYCLES =
    SECTOR_ERASE_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned BLOCK_ERASE_CYCLES =
    BLOCK_ERASE_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned CHIP_ERASE_CYCLES =
    CHIP_ERASE_TIME_US * 1000 / CLK_PERIOD_NS;
  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {
    PH_OPCODE  = 3'b000,
    PH_ADDR    = 3'b001,
    PH_DUMMY   = 3'b010,
    PH_READ    = 3'b011,
    PH_STATUS  = 3'b100,
    PH_PROG    = 3'b101,
    PH_SRDATA  = 3'b110,
    PH_IGNORE  = 3'b111
  } phase_t;
  typedef enum logic [1:0] {
    OPK_PROGRAM = 2'b00,
    OPK_SECTOR  = 2'b01,
    OPK_BLOCK   = 2'b10,
    OPK_CHIP    = 2'b11
  } op_kind_t;
endpackage : flash_cmd_pkg

// File: hdl/flash_cmd.sv
`timescale 1ns/1ps
module flash_cmd
  import flash_cmd_pkg::*;
#(
  parameter int unsigned PROG_CYC   = PROGRAM_CYCLES,
  parameter int unsigned SECTOR_CYC = SECTOR_ERASE_CYCLES,
  parameter int unsigned BLOCK_CYC  = BLOCK_ERASE_CYCLES,
  parameter int unsigned CHIP_CYC   = CHIP_ERASE_CYCLES
) (
  // clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        reset_n_in,
  // serial link pins
  input  wire logic        serial_clk_in,
  input  wire logic        chip_select_n_in,
  input  wire logic        dual_line_0_in,
  output logic             dual_line_0_out,
  output logic             dual_line_0_oe_n_out,
  input  wire logic        dual_line_1_in,
  output logic             dual_line_1_out,
  output logic             dual_line_1_oe_n_out,
  // array read port
  output logic             rd_req_out,
  output logic [18:0]      rd_addr_out,
  input  wire logic [7:0]  rd_data_in,
  // program data stream
  output logic             prog_valid_out,
  output logic [7:0]       prog_col_out,
  output logic [7:0]       prog_data_out,
  input  wire logic        prog_ready_in,
  output logic             prog_overrun_out,
  // protection query
  output logic [23:0]      prot_addr_out,
  input  wire logic        prot_hit_in,
  input  wire logic        any_protected_in,
  // self-timed operation
  output logic             op_start_out,
  output logic [1:0]       op_kind_out,
  output logic [23:0]      op_addr_out,
  output logic             op_done_out,
  // status
  input  wire logic [5:0]  status_upper_in,
  output logic             busy_out,
  output logic             write_enable_latch_out,
  output logic             status_write_out,
  output logic [7:0]       status_write_data_out
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic            sclk_s1, sclk_s2, sclk_d;
    logic            cs_s1, cs_s2, cs_d;
    logic            d0_s1, d0_s2, d1_s1, d1_s2;
    phase_t          phase;
    logic [4:0]      cnt;
    logic [7:0]      opc;
    logic            opc_done;
    logic [23:0]     addr;
    logic            addr_done;
    logic            dual;
    logic [2:0]      oc;
    logic [7:0]      shreg;
    logic [7:0]      next_byte;
    logic [18:0]     rd_addr;
    logic            rd_req, rd_ack;
    logic [7:0]      col;
    logic [7:0]      pbyte;
    logic            byte_seen;
    logic            sr_done;
    logic            wel, busy, pending;
    logic [31:0]     timer;
    op_kind_t        kind;
    logic [23:0]     op_addr;
    logic            op_start, op_done;
    logic            l0, l1, l0_oe_n, l1_oe_n;
    logic            sw, overrun;
    logic [1:0][15:0] fmem;
    logic [1:0]      fcnt;
    logic            fvalid;
  } state_t;

  state_t s, next_s;

  logic sclk_rise, sclk_fall, cs_rise, sel;
  logic push, pop;
  logic [7:0] status_byte;

  assign sclk_rise = s.sclk_s2 & ~s.sclk_d;
  assign sclk_fall = ~s.sclk_s2 & s.sclk_d;
  assign cs_rise   = s.cs_s2 & ~s.cs_d;
  assign sel       = ~s.cs_s2 & ~s.cs_d;
  assign status_byte = {status_upper_in, s.wel, s.busy};

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_s = s;
    push = 1'b0;
    pop  = s.fvalid & prog_ready_in;
    // only the second stage and its delayed copy feed the logic
    next_s.sclk_s1 = serial_clk_in;
    next_s.sclk_s2 = s.sclk_s1;
    next_s.sclk_d  = s.sclk_s2;
    next_s.cs_s1   = chip_select_n_in;
    next_s.cs_s2   = s.cs_s1;
    next_s.cs_d    = s.cs_s2;
    next_s.d0_s1   = dual_line_0_in;
    next_s.d0_s2   = s.d0_s1;
    next_s.d1_s1   = dual_line_1_in;
    next_s.d1_s2   = s.d1_s1;
    next_s.rd_req   = 1'b0;
    next_s.rd_ack   = s.rd_req;
    next_s.op_start = 1'b0;
    next_s.op_done  = 1'b0;
    next_s.sw       = 1'b0;
    if (s.rd_ack) begin
      next_s.next_byte = rd_data_in;
    end

    if (sel && sclk_rise) begin
      next_s.cnt = s.cnt + 5'h01;
      unique case (s.phase)
        PH_OPCODE: begin
          next_s.opc = {s.opc[6:0], s.d0_s2};
          if (s.cnt == LAST_OPC_BIT) begin
            next_s.opc_done = 1'b1;
            next_s.cnt = 5'h00;
            next_s.oc = 3'h0;
            unique case ({s.opc[6:0], s.d0_s2})
              OP_DUAL_OUT, OP_PROGRAM, OP_SECT_ERA_A,
              OP_SECT_ERA_B, OP_BLOCK_ERA:
                next_s.phase = PH_ADDR;
              OP_DUAL_IO: begin
                next_s.phase = PH_ADDR;
                next_s.dual = 1'b1;
              end
              OP_STAT_READ:  next_s.phase = PH_STATUS;
              OP_STAT_WRITE: next_s.phase = PH_SRDATA;
              default:       next_s.phase = PH_IGNORE;
            endcase
          end
        end
        PH_ADDR: begin
          if (s.dual) begin
            next_s.addr = {s.addr[21:0], s.d1_s2, s.d0_s2};
          end else begin
            next_s.addr = {s.addr[22:0], s.d0_s2};
          end
          if ((s.dual && s.cnt == LAST_ADDR_PAIR) ||
              (!s.dual && s.cnt == LAST_ADDR_BIT)) begin
            next_s.cnt = 5'h00;
            next_s.addr_done = 1'b1;
            next_s.rd_addr = next_s.addr[18:0];
            next_s.rd_req  = 1'b1;
            next_s.col     = next_s.addr[7:0];
            if (s.opc == OP_PROGRAM) begin
              next_s.phase = PH_PROG;
            end else if (s.opc == OP_DUAL_OUT || s.dual) begin
              next_s.phase = PH_DUMMY;
            end else begin
              next_s.phase = PH_IGNORE;
            end
          end
        end
        PH_DUMMY: begin
          // line values in the dummy clocks are never looked at
          if ((s.dual && s.cnt == LAST_DUMMY_2) ||
              (!s.dual && s.cnt == LAST_DUMMY_1)) begin
            next_s.phase = PH_READ;
            next_s.cnt = 5'h00;
          end
        end
        PH_PROG: begin
          next_s.pbyte = {s.pbyte[6:0], s.d0_s2};
          if (s.cnt[2:0] == 3'h7) begin
            next_s.cnt = 5'h00;
            next_s.byte_seen = 1'b1;
            next_s.col = s.col + 8'h01;
            push = 1'b1;
          end
        end
        PH_SRDATA: begin
          next_s.pbyte = {s.pbyte[6:0], s.d0_s2};
          if (s.cnt[2:0] == 3'h7) begin
            next_s.sr_done = 1'b1;
            next_s.cnt = 5'h00;
          end
        end
        default: begin
          next_s.cnt = s.cnt;
        end
      endcase
    end

    // outputs change on the falling serial clock
    if (sel && sclk_fall) begin
      if (s.phase == PH_READ) begin
        next_s.oc = {1'b0, s.oc[1:0] + 2'h1};
        next_s.l0_oe_n = 1'b0;
        next_s.l1_oe_n = 1'b0;
        if (s.oc[1:0] == 2'h0) begin
          next_s.l1 = s.next_byte[7];
          next_s.l0 = s.next_byte[6];
          next_s.shreg = {s.next_byte[5:0], 2'b00};
          next_s.rd_addr = (s.rd_addr == TOP_ADDR) ?
                           19'h00000 : s.rd_addr + 19'h00001;
          next_s.rd_req = 1'b1;
        end else begin
          next_s.l1 = s.shreg[7];
          next_s.l0 = s.shreg[6];
          next_s.shreg = {s.shreg[5:0], 2'b00};
        end
      end else if (s.phase == PH_STATUS) begin
        next_s.oc = s.oc + 3'h1;
        next_s.l1_oe_n = 1'b0;
        if (s.oc == 3'h0) begin
          next_s.l1 = status_byte[7];
          next_s.shreg = {status_byte[6:0], 1'b0};
        end else begin
          next_s.l1 = s.shreg[7];
          next_s.shreg = {s.shreg[6:0], 1'b0};
        end
      end
    end

    // select high: release lines and act on the finished command
    if (s.cs_s2) begin
      next_s.l0_oe_n = 1'b1;
      next_s.l1_oe_n = 1'b1;
      next_s.phase = PH_OPCODE;
      next_s.cnt = 5'h00;
      next_s.opc_done = 1'b0;
      next_s.addr_done = 1'b0;
      next_s.dual = 1'b0;
      next_s.byte_seen = 1'b0;
      next_s.sr_done = 1'b0;
    end
    if (cs_rise && s.opc_done) begin
      unique case (s.opc)
        OP_WRITE_ENABLE_CMD: next_s.wel = 1'b1;
        OP_WRITE_DISABLE_CMD: next_s.wel = 1'b0;
        OP_STAT_WRITE: begin
          if (s.sr_done) begin
            next_s.wel = 1'b0;
            next_s.sw = 1'b1;
          end
        end
        OP_PROGRAM: begin
          if (s.byte_seen && s.wel && !s.busy && !prot_hit_in) begin
            next_s.busy = 1'b1;
            next_s.pending = 1'b1;
            next_s.kind = OPK_PROGRAM;
            next_s.op_addr = {s.addr[23:8], 8'h00};
          end
        end
        OP_SECT_ERA_A, OP_SECT_ERA_B: begin
          if (s.addr_done && s.wel && !s.busy && !prot_hit_in) begin
            next_s.busy = 1'b1;
            next_s.pending = 1'b1;
            next_s.kind = OPK_SECTOR;
            next_s.op_addr = {s.addr[23:12], 12'h000};
          end
        end
        OP_BLOCK_ERA: begin
          if (s.addr_done && s.wel && !s.busy && !prot_hit_in) begin
            next_s.busy = 1'b1;
            next_s.pending = 1'b1;
            next_s.kind = OPK_BLOCK;
            next_s.op_addr = {s.addr[23:16], 16'h0000};
          end
        end
        OP_CHIP_ERA_A, OP_CHIP_ERA_B: begin
          if (s.wel && !s.busy && !any_protected_in) begin
            next_s.busy = 1'b1;
            next_s.pending = 1'b1;
            next_s.kind = OPK_CHIP;
            next_s.op_addr = 24'h000000;
          end
        end
        default: begin
          next_s.wel = s.wel;
        end
      endcase
    end

    // ****************************************
    // self-timed operation
    // ****************************************
    // a program waits for its bytes to drain before it starts
    if (s.pending && (s.kind != OPK_PROGRAM || !s.fvalid)) begin
      next_s.pending = 1'b0;
      next_s.op_start = 1'b1;
      unique case (s.kind)
        OPK_PROGRAM: next_s.timer = 32'(PROG_CYC);
        OPK_SECTOR:  next_s.timer = 32'(SECTOR_CYC);
        OPK_BLOCK:   next_s.timer = 32'(BLOCK_CYC);
        OPK_CHIP:    next_s.timer = 32'(CHIP_CYC);
      endcase
    end else if (s.busy && !s.pending) begin
      if (s.timer <= 32'h00000001) begin
        next_s.busy = 1'b0;
        // a write enable landing in the same cycle wins
        if (!(cs_rise && s.opc_done && s.opc == OP_WRITE_ENABLE_CMD)) begin
          next_s.wel = 1'b0;
        end
        next_s.op_done = 1'b1;
      end else begin
        next_s.timer = s.timer - 32'h00000001;
      end
    end

    // ****************************************
    // two-entry program byte buffer
    // ****************************************
    // the array sees each byte with its page column, except one pushed while both
    // entries are full and none leaves in the same cycle, which is dropped and sets overrun; later bytes to the same column overwrite, so the last 256 survive
    if (pop) begin
      next_s.fmem[0] = s.fmem[1];
    end
    if (push) begin
      if (s.fcnt == 2'h2 && !pop) begin
        next_s.overrun = 1'b1;
      end else if ((s.fcnt == 2'h0) || (s.fcnt == 2'h1 && pop)) begin
        next_s.fmem[0] = {s.col, next_s.pbyte};
      end else begin
        next_s.fmem[1] = {s.col, next_s.pbyte};
      end
    end
    if (push && !(s.fcnt == 2'h2 && !pop) && !pop) begin
      next_s.fcnt = s.fcnt + 2'h1;
    end else if (pop && !push) begin
      next_s.fcnt = s.fcnt - 2'h1;
    end
    next_s.fvalid = (next_s.fcnt != 2'h0);
    if (cs_rise && s.opc == OP_PROGRAM) begin
      next_s.overrun = 1'b0;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s <= '0;
      s.sclk_s1 <= 1'b0;
      s.cs_s1 <= 1'b1;
      s.cs_s2 <= 1'b1;
      s.cs_d <= 1'b1;
      s.l0_oe_n <= 1'b1;
      s.l1_oe_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign dual_line_0_out        = s.l0;
  assign dual_line_0_oe_n_out   = s.l0_oe_n;
  assign dual_line_1_out        = s.l1;
  assign dual_line_1_oe_n_out   = s.l1_oe_n;
  assign rd_req_out             = s.rd_req;
  assign rd_addr_out            = s.rd_addr;
  assign prog_valid_out         = s.fvalid;
  assign prog_col_out           = s.fmem[0][15:8];
  assign prog_data_out          = s.fmem[0][7:0];
  assign prog_overrun_out       = s.overrun;
  assign prot_addr_out          = s.addr;
  assign op_start_out           = s.op_start;
  assign op_kind_out            = s.kind;
  assign op_addr_out            = s.op_addr;
  assign op_done_out            = s.op_done;
  assign busy_out               = s.busy;
  assign write_enable_latch_out = s.wel;
  assign status_write_out       = s.sw;
  assign status_write_data_out  = s.pbyte;

endmodule : flash_cmd

// File: test/flash_cmd_props.sv
`timescale 1ns/1ps
module flash_cmd_props #(
  parameter int unsigned PROG_CYC   = 20,
  parameter int unsigned SECTOR_CYC = 20,
  parameter int unsigned BLOCK_CYC  = 20,
  parameter int unsigned CHIP_CYC   = 20
) (
  // clock and reset
  input wire logic        ref_clk_in,
  input wire logic        reset_n_in,
  // link and array side
  input wire logic        chip_select_n_in,
  input wire logic        dual_line_0_oe_n_out,
  input wire logic        dual_line_1_oe_n_out,
  input wire logic        rd_req_out,
  input wire logic [18:0] rd_addr_out,
  input wire logic        any_protected_in,
  // self-timed operation and status
  input wire logic        op_start_out,
  input wire logic [1:0]  op_kind_out,
  input wire logic [23:0] op_addr_out,
  input wire logic        op_done_out,
  input wire logic        busy_out,
  input wire logic        write_enable_latch_out
);
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!reset_n_in);
  // ****************************************
  // helper state
  // ****************************************
  logic        in_read;
  logic [18:0] last_addr;
  int unsigned op_cnt;
  int unsigned op_lim;
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      in_read   <= 1'b0;
      last_addr <= 19'h0;
      op_cnt    <= 0;
      op_lim    <= 0;
    end else begin
      in_read <= !chip_select_n_in && (rd_req_out || in_read);
      if (rd_req_out) begin
        last_addr <= rd_addr_out;
      end
      // counts from the start pulse, kind fixed at start
      if (op_start_out) begin
        op_cnt <= 0;
        op_lim <= op_kind_out == 2'h0 ? PROG_CYC :
                  op_kind_out == 2'h1 ? SECTOR_CYC :
                  op_kind_out == 2'h2 ? BLOCK_CYC : CHIP_CYC;
      end else begin
        op_cnt <= op_cnt + 1;
      end
    end
  end
  // ****************************************
  // properties
  // ****************************************
  sequence s_idle;
    !busy_out && !write_enable_latch_out;
  endsequence
  sequence s_held;
    busy_out [*2];
  endsequence
  property p_release;
    chip_select_n_in [*8] |-> dual_line_0_oe_n_out && dual_line_1_oe_n_out;
  endproperty
  property p_addr_step;
    rd_req_out && in_read |-> rd_addr_out == last_addr + 19'h1;
  endproperty
  property p_start_busy;
    op_start_out |=> s_held;
  endproperty
  property p_start_latch;
    op_start_out |-> write_enable_latch_out;
  endproperty
  property p_done_idle;
    op_done_out |-> ##[0:1] s_idle;
  endproperty
  property p_op_len;
    op_done_out |-> op_cnt + 2 >= op_lim && op_cnt <= op_lim + 1;
  endproperty
  property p_chip;
    op_start_out && op_kind_out == 2'h3 |->
      !any_protected_in && op_addr_out == 24'h0;
  endproperty
  property p_sector;
    op_start_out && op_kind_out == 2'h1 |-> op_addr_out[11:0] == 12'h0;
  endproperty
  property p_block;
    op_start_out && op_kind_out == 2'h2 |-> op_addr_out[15:0] == 16'h0;
  endproperty
  a_release: assert property (p_release)
    else $error("data lines driven while deselected");
  a_addr_step: assert property (p_addr_step)
    else $error("read address not sequential");
  a_start_busy: assert property (p_start_busy)
    else $error("busy not held after start");
  a_start_latch: assert property (p_start_latch)
    else $error("operation started without latch");
  a_done_idle: assert property (p_done_idle)
    else $error("busy or latch left after done");
  a_op_len: assert property (p_op_len)
    else $error("operation length wrong");
  a_chip: assert property (p_chip)
    else $error("chip erase wrong");
  a_sector: assert property (p_sector)
    else $error("sector base wrong");
  a_block: assert property (p_block)
    else $error("block base wrong");
endmodule : flash_cmd_props

// File: test/spi_host_model.sv
`timescale 1ns/1ps
module spi_host_model (
  // clock
  input  wire logic       ref_clk_in,
  // device side of both data lines
  input  wire logic [1:0] dev_out_in,
  input  wire logic [1:0] dev_oe_n_in,
  // link pins
  output logic            sck_out,
  output logic            cs_n_out,
  output logic [1:0]      line_out
);
  logic [1:0] drv = 2'h0;
  logic [1:0] drv_en = 2'h0;
  logic [1:0] float_pat = 2'h1;
  initial begin
    sck_out = 1'b0;
    cs_n_out = 1'b1;
  end
  // released lines toggle so a stale level never reads as valid
  always @(posedge ref_clk_in) begin
    float_pat <= ~float_pat;
  end
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      line_out[i] = !dev_oe_n_in[i] ? dev_out_in[i] :
                    drv_en[i] ? drv[i] : float_pat[i];
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask : tick
  // data set at the fall, taken at the rise, 160 ns per clock
  task automatic pair(input logic [1:0] en, input logic [1:0] v,
                      output logic [1:0] got);
    drv    <= v;
    drv_en <= en;
    tick(8);
    got = line_out;
    sck_out <= 1'b1;
    tick(8);
    sck_out <= 1'b0;
  endtask : pair
  task automatic byte1(input logic [7:0] b, output logic [7:0] r);
    logic [1:0] g;
    for (int i = 7; i >= 0; i--) begin
      pair(2'b01, {1'b0, b[i]}, g);
      r[i] = g[1];
    end
  endtask : byte1
  task automatic dual(input logic [1:0] en, input logic [7:0] b,
                      output logic [7:0] r);
    logic [1:0] g;
    for (int k = 3; k >= 0; k--) begin
      pair(en, b[2*k +: 2], g);
      r[2*k +: 2] = g;
    end
  endtask : dual
  task automatic sel();
    tick(10);
    cs_n_out <= 1'b0;
    tick(4);
  endtask : sel
  // select stays low until the last clock has fallen
  task automatic desel();
    tick(8);
    drv_en   <= 2'h0;
    cs_n_out <= 1'b1;
  endtask : desel
endmodule : spi_host_model

// File: test/flash_cmd_tb.sv
`timescale 1ns/1ps
module flash_cmd_tb;
  import flash_cmd_pkg::*;
  localparam int unsigned PC = 600;
  localparam int unsigned EC = 20;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  wire         sck, cs_n;
  wire  [1:0]  ln;
  logic [1:0]  dout, doe_n, op_kind;
  logic        rd_req, pv, op_start, op_done, busy, wel;
  logic        prdy = 1'b0;
  logic        any_prot = 1'b0;
  logic [18:0] rd_addr;
  logic [7:0]  pcol, pdat, r, swd;
  logic [7:0]  rd_data = 8'h0;
  logic [7:0]  prot_blk = 8'hff;
  logic [23:0] prot_addr, op_addr;
  logic [5:0]  up = 6'h0;
  logic [15:0] pq[$], ex[$];
  int          n_fail = 0;
  int          checks_done = 0;
  wire         prot_hit = prot_addr[23:16] == prot_blk;
  always #5 clk = ~clk;
  flash_cmd #(.PROG_CYC(PC), .SECTOR_CYC(EC), .BLOCK_CYC(EC), .CHIP_CYC(EC))
  DUT (.ref_clk_in(clk), .reset_n_in(rst_n), .serial_clk_in(sck),
    .chip_select_n_in(cs_n), .dual_line_0_in(ln[0]),
    .dual_line_0_out(dout[0]), .dual_line_0_oe_n_out(doe_n[0]),
    .dual_line_1_in(ln[1]), .dual_line_1_out(dout[1]),
    .dual_line_1_oe_n_out(doe_n[1]), .rd_req_out(rd_req),
    .rd_addr_out(rd_addr), .rd_data_in(rd_data), .prog_valid_out(pv),
    .prog_col_out(pcol), .prog_data_out(pdat), .prog_ready_in(prdy),
    .prog_overrun_out(), .prot_addr_out(prot_addr), .prot_hit_in(prot_hit),
    .any_protected_in(any_prot), .op_start_out(op_start),
    .op_kind_out(op_kind), .op_addr_out(op_addr), .op_done_out(op_done),
    .status_upper_in(up), .busy_out(busy), .write_enable_latch_out(wel),
    .status_write_out(), .status_write_data_out(swd));
  spi_host_model host (.ref_clk_in(clk), .dev_out_in(dout),
    .dev_oe_n_in(doe_n), .sck_out(sck), .cs_n_out(cs_n), .line_out(ln));
  function automatic logic [7:0] arr(input logic [18:0] a);
    return a[7:0] ^ a[15:8] ^ {5'h0, a[18:16]};
  endfunction : arr
  // array answers next cycle; program side stalls at random
  always @(posedge clk) begin
    rd_data <= arr(rd_addr);
    prdy    <= 1'($urandom);
    if (pv && prdy) pq.push_back({pcol, pdat});
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cmd(input logic [7:0] oc, input logic [23:0] a,
                     input bit with_addr);
    host.sel();
    host.byte1(oc, r);
    for (int i = 2; i >= 0 && with_addr; i--) host.byte1(a[8*i +: 8], r);
  endtask : cmd
  task automatic status(input logic [1:0] low);
    cmd(OP_STAT_READ, 24'h0, 0);
    repeat (2) begin
      host.byte1(8'h00, r);
      chk(24'(r), 24'({up, low}));
    end
    host.desel();
  endtask : status
  task automatic prog(input logic [23:0] a, input int n);
    logic [1:0] g;
    logic [7:0] d;
    cmd(OP_PROGRAM, a, 1);
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      ex.push_back({a[7:0] + 8'(i), d});
      host.byte1(d, r);
    end
    repeat (3) host.pair(2'b01, 2'b01, g);
    host.desel();
  endtask : prog
  task automatic rd(input logic [7:0] oc, input logic [23:0] a);
    logic [1:0] g;
    cmd(oc, a, oc == OP_DUAL_OUT);
    for (int i = 2; i >= 0 && oc == OP_DUAL_IO; i--) begin
      host.dual(2'b11, a[8*i +: 8], r);
    end
    // dummy clocks with both lines already let go
    repeat (oc == OP_DUAL_IO ? 4 : 8) host.pair(2'b00, 2'b00, g);
    for (int i = 0; i < 4; i++) begin
      host.dual(2'b00, 8'h00, r);
      chk(24'(r), 24'(arr(19'(a + 24'(i)))));
    end
    host.desel();
  endtask : rd
  task automatic wait_op(input bit want, input logic [1:0] k,
                         input logic [23:0] a);
    int n;
    n = 0;
    repeat (300) begin
      if (op_start === 1'b1) break;
      @(posedge clk);
    end
    chk(24'(op_start === want), 24'h1);
    if (want && op_start === 1'b1) begin
      chk(24'(op_kind), 24'(k));
      chk(op_addr, k == 2'h0 ? a & 24'hffff00 : k == 2'h1 ? a & 24'hfff000 :
          k == 2'h2 ? a & 24'hff0000 : 24'h0);
      while (op_done !== 1'b1) begin
        @(posedge clk);
        if (++n > 2000) begin
          n_fail++;
          close_out();
        end
      end
      repeat (3) @(posedge clk);
      chk(24'({busy, wel}), 24'h0);
    end
  endtask : wait_op
  logic [7:0] eop [5] = '{OP_SECT_ERA_A, OP_SECT_ERA_B, OP_BLOCK_ERA,
                          OP_CHIP_ERA_A, OP_CHIP_ERA_B};
  logic [1:0] ekd [5] = '{2'h1, 2'h1, 2'h2, 2'h3, 2'h3};
  initial begin
    logic [23:0] a;
    int          j;
    void'($urandom(32'h24ed));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    up    <= 6'($urandom);
    cmd(OP_WRITE_ENABLE_CMD, 24'h0, 0);
    host.desel();
    status(2'b10);
    cmd(OP_STAT_WRITE, 24'h0, 0);
    host.byte1(8'h5a, r);
    host.desel();
    repeat (6) @(posedge clk);
    chk(24'(swd), 24'h00005a);
    status(2'b00);
    cmd(OP_WRITE_ENABLE_CMD, 24'h0, 0);
    host.desel();
    cmd(OP_WRITE_DISABLE_CMD, 24'h0, 0);
    host.desel();
    status(2'b00);
    prog(24'h000100, 1);
    wait_op(0, 2'h0, 24'h0);
    cmd(OP_WRITE_ENABLE_CMD, 24'h0, 0);
    host.desel();
    pq.delete();
    ex.delete();
    prog(24'h0123fe, 3);
    fork
      wait_op(1, 2'h0, 24'h0123fe);
      status(2'b11);
    join
    chk(24'(pq.size()), 24'h3);
    foreach (ex[i]) chk(24'(pq[i]), 24'(ex[i]));
    rd(OP_DUAL_OUT, 24'h07fffe);
    rd(OP_DUAL_IO, 24'($urandom) & 24'h07ffff);
    for (int i = 0; i < 7; i++) begin
      a = 24'($urandom) & 24'h07ffff;
      // last pass is a chip erase refused by any protected area
      j = i == 6 ? 3 : i % 5;
      prot_blk <= i == 5 ? a[23:16] : 8'hff;
      any_prot <= i == 6;
      cmd(OP_WRITE_ENABLE_CMD, 24'h0, 0);
      host.desel();
      cmd(eop[j], a, ekd[j] != 2'h3);
      host.desel();
      wait_op(i < 5, ekd[j], a);
    end
    close_out();
  end
endmodule : flash_cmd_tb
bind flash_cmd flash_cmd_props #(.PROG_CYC(PROG_CYC),
  .SECTOR_CYC(SECTOR_CYC), .BLOCK_CYC(BLOCK_CYC), .CHIP_CYC(CHIP_CYC))
  props (.ref_clk_in, .reset_n_in, .chip_select_n_in, .dual_line_0_oe_n_out,
  .dual_line_1_oe_n_out, .rd_req_out, .rd_addr_out, .any_protected_in,
  .op_start_out, .op_kind_out, .op_addr_out, .op_done_out, .busy_out,
  .write_enable_latch_out);
